// file: ies_chan_mem.sv
// Purpose: Pointer and counter store for the event transfer channels
// Assumes: One write port, one read port, read data registered
// Notes:   Contents are not cleared by reset; software loads each channel
`timescale 1ns/1ps
`default_nettype none
module ies_chan_mem
  import ies_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 we_i,
  input  wire logic [CH_IDX_W-1:0]  waddr_i,
  input  wire logic [CH_WORD_W-1:0] wdata_i,
  input  wire logic [CH_IDX_W-1:0]  raddr_i,
  output logic      [CH_WORD_W-1:0] rdata_o
);

  logic [CH_WORD_W-1:0] mem_q [CHANNELS];

  // Write port
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // Registered read, write-through not needed by the sequencer
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule
`default_nettype wire

// file: ies_cpu_model.sv
// Purpose: CPU side model that answers vector and move requests
// Assumes: Each request stands until the CPU acknowledges it
// Notes:   slow_i makes the CPU wait three extra cycles before answering
`timescale 1ns/1ps
`default_nettype none
module ies_cpu_model (
  input  wire logic clk_i,
  input  wire logic svc_req_i,
  input  wire logic mv_req_i,
  input  wire logic slow_i,
  output logic      svc_ack_o,
  output logic      mv_ack_o
);
  logic [1:0] wait_q = 2'h0;
  // One-cycle acknowledge after an optional wait
  always_ff @(posedge clk_i) begin
    svc_ack_o <= 1'b0;
    mv_ack_o  <= 1'b0;
    if ((svc_req_i || mv_req_i) && !svc_ack_o && !mv_ack_o) begin
      wait_q <= wait_q + 2'h1;
      if (!slow_i || wait_q == 2'h3) begin
        svc_ack_o <= svc_req_i;
        mv_ack_o  <= mv_req_i && !svc_req_i;
        wait_q    <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: ies_ctrl.sv
// Purpose: Node arbitration, vector sequencing, transfer channels, router and traps
// Assumes: CPU answers svc_req_o with svc_ack_i and mv_req_o with mv_ack_i
// Notes:   Contract
`timescale 1ns/1ps
`default_nettype none
module ies_ctrl
  import ies_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          nrst_i,
  input  wire logic [DED_NODES-1:0]          src_req_i,
  input  wire logic [SHR_SRCS-1:0]           shr_src_i,
  input  wire logic [SHR_NODES*SHR_SEL_W-1:0] node_sel_i,
  input  wire logic [NODES-1:0]              node_en_i,
  input  wire logic [NODES*PRIO_W-1:0]       node_prio_i,
  input  wire logic [NODES-1:0]              node_use_chan_i,
  input  wire logic [NODES*CH_IDX_W-1:0]     node_chan_i,
  input  wire logic [NODES-1:0]              sw_set_i,
  input  wire logic [NODES-1:0]              sw_clr_i,
  input  wire logic [PRIO_W-1:0]             cpu_level_i,
  input  wire logic                          jcache_i,
  input  wire logic                          svc_ack_i,
  input  wire logic                          mv_ack_i,
  input  wire logic [CHANNELS-1:0]           ch_inc_src_i,
  input  wire logic [CHANNELS-1:0]           ch_inc_dst_i,
  input  wire logic [CHANNELS-1:0]           ch_word_i,
  input  wire logic [CHANNELS-1:0]           ch_cont_i,
  input  wire logic                          ch_wr_i,
  input  wire logic [CH_IDX_W-1:0]           ch_wr_sel_i,
  input  wire logic [CH_WORD_W-1:0]          ch_wr_data_i,
  input  wire logic [ER_CH-1:0]              er_in_i,
  input  wire logic [2*ER_CH-1:0]            er_edge_cfg_i,
  input  wire logic [ER_GATES*ER_CH-1:0]     er_route_i,
  input  wire logic [ER_GATES*ER_CH-1:0]     er_pat_i,
  input  wire logic [ER_GATES*ER_CH-1:0]     er_pmask_i,
  input  wire logic [2*ER_GATES-1:0]         er_gmode_i,
  input  wire logic [ER_CH-1:0]              er_flag_clr_i,
  input  wire logic [HW_TRAPS-1:0]           hw_trap_i,
  input  wire logic [EXT_PINS-1:0]           ext_trap_i,
  input  wire logic [EXT_PINS-1:0]           ext_en_i,
  input  wire logic [EXT_PINS-1:0]           ext_map_i,
  input  wire logic [TRAPS-1:0]              trap_flag_clr_i,
  input  wire logic                          trap_done_i,
  input  wire logic                          swtrap_i,
  input  wire logic [7:0]                    swtrap_num_i,
  output logic                               svc_req_o,
  output logic      [7:0]                    svc_vec_o,
  output logic      [PRIO_W-1:0]             svc_lvl_o,
  output logic                               svc_trap_o,
  output logic                               mv_req_o,
  output logic      [PTR_W-1:0]              mv_src_o,
  output logic      [PTR_W-1:0]              mv_dst_o,
  output logic                               mv_word_o,
  output logic                               ch_wr_ready_o,
  output logic      [NODES-1:0]              node_req_o,
  output logic      [TRAPS-1:0]              trap_flag_o,
  output logic                               trap_busy_o,
  output logic      [ER_CH-1:0]              er_flag_o
);

  ies_state_t s_q;
  ies_state_t s_d;

  logic [ER_CH-1:0]     er_evt;
  logic [ER_GATES-1:0]  er_out;
  logic [SHR_NODES-1:0] shr_req;
  logic [NODES-1:0]     hw_set;
  logic [TRAPS-1:0]     trap_evt;
  logic [EXT_PINS-1:0]  ext_rise;
  logic                 sys_req_a;
  logic                 sys_req_b;

  logic                 mem_we;
  logic [CH_IDX_W-1:0]  mem_waddr;
  logic [CH_WORD_W-1:0] mem_wdata;
  logic [CH_IDX_W-1:0]  mem_raddr;
  logic [CH_WORD_W-1:0] mem_rdata;
  logic [PTR_W-1:0]     rd_src;
  logic [PTR_W-1:0]     rd_dst;
  logic [CNT_W-1:0]     rd_cnt;
  logic [CNT_W-1:0]     new_cnt;
  logic [PTR_W-1:0]     step;

  logic                 win_found;
  logic [6:0]           win_idx;
  logic [PRIO_W-1:0]    win_prio;
  logic [CH_IDX_W-1:0]  win_chan;
  logic                 grant;
  logic                 trap_found;
  logic [2:0]           trap_top;
  logic                 trap_go;

  // Router channels and shared node source muxes
  genvar g;
  generate
    for (g = 0; g < ER_CH; g++) begin : g_router
      logic match;
      assign er_evt[g] = (er_in_i[g] & ~s_q.er_prev[g] & er_edge_cfg_i[2*g])
                       | (~er_in_i[g] & s_q.er_prev[g] & er_edge_cfg_i[2*g+1]);
      assign match = ((s_q.er_flag ^ er_pat_i[g*ER_CH +: ER_CH]) & er_pmask_i[g*ER_CH +: ER_CH]) == '0;
      always_comb begin
        case (er_gmode_i[2*g +: 2])
          OGU_PASS:  er_out[g] = |(er_evt & er_route_i[g*ER_CH +: ER_CH]);
          OGU_MATCH: er_out[g] = |(er_evt & er_route_i[g*ER_CH +: ER_CH]) & match;
          OGU_MISS:  er_out[g] = |(er_evt & er_route_i[g*ER_CH +: ER_CH]) & ~match;
          default:   er_out[g] = 1'b0;
        endcase
      end
    end
    for (g = 0; g < SHR_NODES; g++) begin : g_shared
      assign shr_req[g] = shr_src_i[node_sel_i[g*SHR_SEL_W +: SHR_SEL_W]];
    end
  endgenerate

  // Hardware request sources per node and trap events
  assign hw_set    = {er_out, shr_req, src_req_i};
  assign ext_rise  = ext_trap_i & ~s_q.ext_prev & ext_en_i;
  assign sys_req_a = |(ext_rise & ~ext_map_i);
  assign sys_req_b = |(ext_rise & ext_map_i);
  assign trap_evt  = {sys_req_b, sys_req_a, hw_trap_i};

  // Channel word fields
  assign rd_src  = mem_rdata[CH_SRC_LSB +: PTR_W];
  assign rd_dst  = mem_rdata[CH_DST_LSB +: PTR_W];
  assign rd_cnt  = mem_rdata[CH_CNT_LSB +: CNT_W];
  assign new_cnt = ch_cont_i[s_q.ch] ? rd_cnt : rd_cnt - 8'h01;
  assign step    = ch_word_i[s_q.ch] ? STEP_WORD : STEP_BYTE;

  // Highest-priority enabled node, lowest index on a tie
  always_comb begin
    win_found = 1'b0;
    win_idx   = '0;
    win_prio  = '0;
    for (int n = 0; n < NODES; n++) begin
      if (s_q.req[n] && node_en_i[n] &&
          (!win_found || node_prio_i[n*PRIO_W +: PRIO_W] > win_prio)) begin
        win_found = 1'b1;
        win_idx   = 7'(n);
        win_prio  = node_prio_i[n*PRIO_W +: PRIO_W];
      end
    end
  end

  // Highest pending trap and its right to preempt
  always_comb begin
    trap_found = 1'b0;
    trap_top   = '0;
    for (int t = 0; t < TRAPS; t++) begin
      if (s_q.tpend[t]) begin
        trap_found = 1'b1;
        trap_top   = 3'(t);
      end
    end
  end

  assign win_chan = node_chan_i[win_idx*CH_IDX_W +: CH_IDX_W];
  assign trap_go  = trap_found && (!s_q.trap_busy || trap_top > s_q.trap_lvl);
  assign grant    = s_q.st == ST_IDLE && !trap_go && !s_q.trap_busy && !s_q.sw_pend
                  && win_found && win_prio > cpu_level_i;

  // Channel memory port steering; the sequencer write-back has priority
  always_comb begin
    mem_raddr = (s_q.st == ST_IDLE) ? win_chan : s_q.ch;
    mem_we    = 1'b0;
    mem_waddr = ch_wr_sel_i;
    mem_wdata = ch_wr_data_i;
    if (s_q.st == ST_UPD) begin
      mem_we    = 1'b1;
      mem_waddr = s_q.ch;
      mem_wdata = {ch_inc_src_i[s_q.ch] ? rd_src + step : rd_src,
                   ch_inc_dst_i[s_q.ch] ? rd_dst + step : rd_dst,
                   new_cnt};
    end else if (ch_wr_i) begin
      mem_we    = 1'b1;
    end
  end

  ies_chan_mem u_mem (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rdata)
  );

  // Next state: flags, router, traps and the service sequencer
  always_comb begin
    s_d          = s_q;
    s_d.er_prev  = er_in_i;
    s_d.ext_prev = ext_trap_i;
    s_d.er_flag  = (s_q.er_flag & ~er_flag_clr_i) | er_evt;
    s_d.tflag    = (s_q.tflag & ~trap_flag_clr_i) | trap_evt;
    s_d.req      = s_q.req & ~sw_clr_i;
    if (trap_done_i) begin
      s_d.trap_busy = 1'b0;
    end
    if (swtrap_i) begin
      s_d.sw_pend = 1'b1;
      s_d.sw_num  = swtrap_num_i;
    end
    case (s_q.st)
      ST_IDLE: begin
        if (trap_go) begin
          s_d.tpend[trap_top] = 1'b0;
          s_d.vec     = {5'h00, trap_top};
          s_d.lvl     = TRAP_LEVEL;
          s_d.is_trap = 1'b1;
          s_d.hw_trap = 1'b1;
          s_d.cnt     = jcache_i ? RESP_JC_LOAD : RESP_NJC_LOAD;
          s_d.st      = ST_RESP;
        end else if (s_q.sw_pend && !swtrap_i) begin
          s_d.sw_pend = 1'b0;
          s_d.vec     = s_q.sw_num;
          s_d.lvl     = TRAP_LEVEL;
          s_d.is_trap = 1'b1;
          s_d.hw_trap = 1'b0;
          s_d.cnt     = jcache_i ? RESP_JC_LOAD : RESP_NJC_LOAD;
          s_d.st      = ST_RESP;
        end else if (grant) begin
          s_d.req[win_idx] = 1'b0;
          s_d.node    = win_idx;
          s_d.lvl     = win_prio;
          s_d.vec     = 8'(NODE_VEC_BASE + {1'b0, win_idx});
          s_d.is_trap = 1'b0;
          s_d.hw_trap = 1'b0;
          s_d.ch      = win_chan;
          s_d.cnt     = jcache_i ? RESP_JC_LOAD : RESP_NJC_LOAD;
          s_d.st      = node_use_chan_i[win_idx] ? ST_RD : ST_RESP;
        end
      end
      ST_RESP: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h0) begin
          s_d.st = ST_VEC;
        end
      end
      ST_VEC: begin
        if (svc_ack_i) begin
          if (s_q.hw_trap) begin
            s_d.trap_busy = 1'b1;
            s_d.trap_lvl  = s_q.vec[2:0];
          end
          s_d.st = ST_IDLE;
        end
      end
      ST_RD: begin
        s_d.mword = ch_word_i[s_q.ch];
        if (!ch_cont_i[s_q.ch] && rd_cnt == 8'h00) begin
          s_d.cnt = jcache_i ? RESP_JC_LOAD : RESP_NJC_LOAD;
          s_d.st  = ST_RESP;
        end else begin
          s_d.st = ST_MOVE;
        end
      end
      ST_MOVE: begin
        if (mv_ack_i) begin
          s_d.st = ST_UPD;
        end
      end
      ST_UPD: begin
        if (!ch_cont_i[s_q.ch] && new_cnt == 8'h00) begin
          s_d.cnt = jcache_i ? RESP_JC_LOAD : RESP_NJC_LOAD;
          s_d.st  = ST_RESP;
        end else begin
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    s_d.req   = s_d.req | hw_set | sw_set_i;
    s_d.tpend = s_d.tpend | trap_evt;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_q <= IES_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign svc_req_o     = s_q.st == ST_VEC;
  assign svc_vec_o     = s_q.vec;
  assign svc_lvl_o     = s_q.lvl;
  assign svc_trap_o    = s_q.is_trap;
  assign mv_req_o      = s_q.st == ST_MOVE;
  assign mv_src_o      = rd_src;
  assign mv_dst_o      = rd_dst;
  assign mv_word_o     = s_q.mword;
  assign ch_wr_ready_o = s_q.st != ST_UPD;
  assign node_req_o    = s_q.req;
  assign trap_flag_o   = s_q.tflag;
  assign trap_busy_o   = s_q.trap_busy;
  assign er_flag_o     = s_q.er_flag;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence resp_start;
    s_d.st == ST_RESP && s_q.st != ST_RESP;
  endsequence
  sequence quiet_jc;
    !svc_req_o [*6] ##1 svc_req_o;
  endsequence
  sequence quiet_njc;
    !svc_req_o [*8] ##1 !svc_req_o ##1 !svc_req_o ##1 svc_req_o;
  endsequence

  a_resp_jc_wait: assert property (resp_start ##0 jcache_i |=> quiet_jc)
    else $error("vector not presented 7 clocks after start");
  a_resp_njc_wait: assert property (resp_start ##0 !jcache_i |=> quiet_njc)
    else $error("vector not presented 11 clocks after start");
  a_auto_clear: assert property (grant && !hw_set[win_idx] && !sw_set_i[win_idx]
    |=> !s_q.req[$past(win_idx)])
    else $error("accepted node flag not cleared");
  a_sw_set_req: assert property (sw_set_i != '0
    |=> (s_q.req & $past(sw_set_i)) == $past(sw_set_i))
    else $error("software set did not raise request");
  a_trap_flag_set: assert property (trap_evt != '0
    |=> (trap_flag_o & $past(trap_evt)) == $past(trap_evt))
    else $error("trap flag bit not set");
  a_trap_blocks_irq: assert property (s_q.trap_busy && s_q.st == ST_IDLE
    |-> s_d.st != ST_RD && !(s_d.st == ST_RESP && !s_d.is_trap))
    else $error("service started during trap");
  a_trap_preempt: assert property (s_q.st == ST_IDLE && trap_go
    |=> s_q.st == ST_RESP && s_q.is_trap && s_q.vec == {5'h00, $past(trap_top)})
    else $error("trap did not preempt");
  a_move_one_cycle: assert property (mv_req_o && mv_ack_i
    |=> !mv_req_o ##1 !mv_req_o)
    else $error("move took more than one cycle");
  a_cnt_decrement: assert property (mv_req_o && mv_ack_i && !ch_cont_i[s_q.ch]
    |=> mem_we && mem_wdata[CH_CNT_LSB +: CNT_W] == $past(rd_cnt) - 8'h01)
    else $error("transfer count not decremented");
  a_end_irq: assert property (s_q.st == ST_UPD && !ch_cont_i[s_q.ch]
    && new_cnt == 8'h00 |=> s_q.st == ST_RESP && s_q.vec == 8'(NODE_VEC_BASE + {1'b0, s_q.node}))
    else $error("count end did not raise node interrupt");
  a_edge_rise: assert property ($rose(er_in_i[0]) && er_edge_cfg_i[0]
    |=> er_flag_o[0])
    else $error("rising edge not detected");

endmodule
`default_nettype wire

// file: ies_pkg.sv
// Purpose: Shared constants and types for the interrupt and event transfer system
// Assumes: One CPU clock at 125 MHz; all inputs synchronous to it
// Notes:   Node map: 0..83 dedicated, 84..91 shared, 92..95 router outputs
package ies_pkg;

  // Sizes of the node array, the router, the channel set, the external pins and the traps
  localparam int NODES       = 96;
  localparam int PRIO_W      = 4;
  localparam int DED_NODES   = 84;
  localparam int SHR_NODES   = 8;
  localparam int SHR_SRCS    = 16;
  localparam int SHR_SEL_W   = 4;
  localparam int ER_CH       = 4;
  localparam int ER_GATES    = 4;
  localparam int CHANNELS    = 8;
  localparam int CH_IDX_W    = 3;
  localparam int PTR_W       = 24;
  localparam int CNT_W       = 8;
  localparam int CH_WORD_W   = 2 * PTR_W + CNT_W;
  localparam int EXT_PINS    = 3;
  localparam int TRAPS       = 8;

  // Field layout of one channel word in the channel memory
  localparam int CH_SRC_LSB  = 32;
  localparam int CH_DST_LSB  = 8;
  localparam int CH_CNT_LSB  = 0;

  // Trap flag bit positions driven by the external trap inputs, and the hardware trap count
  localparam int TRAP_SRA_BIT = 6;
  localparam int TRAP_SRB_BIT = 7;
  localparam int HW_TRAPS     = 6;

  // Vector numbering and levels
  localparam logic [7:0]        NODE_VEC_BASE = 8'h10;
  localparam logic [PRIO_W-1:0] TRAP_LEVEL    = 4'hf;

  // Response latency in CPU clocks, with and without the jump cache
  localparam int RESP_JC_CYC  = 7;
  localparam int RESP_NJC_CYC = 11;
  localparam logic [3:0] RESP_JC_LOAD  = 4'(RESP_JC_CYC - 2);
  localparam logic [3:0] RESP_NJC_LOAD = 4'(RESP_NJC_CYC - 2);

  // Pointer steps for byte and word moves
  localparam logic [PTR_W-1:0] STEP_BYTE = 24'h000001;
  localparam logic [PTR_W-1:0] STEP_WORD = 24'h000002;

  // Output gating modes
  localparam logic [1:0] OGU_BLOCK = 2'h0;
  localparam logic [1:0] OGU_PASS  = 2'h1;
  localparam logic [1:0] OGU_MATCH = 2'h2;
  localparam logic [1:0] OGU_MISS  = 2'h3;

  // Sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RESP = 6'h02,
    ST_VEC  = 6'h04,
    ST_RD   = 6'h08,
    ST_MOVE = 6'h10,
    ST_UPD  = 6'h20
  } ies_st_t;

  // Whole state of the controller except the channel memory
  typedef struct packed {
    ies_st_t             st;
    logic [3:0]          cnt;
    logic [NODES-1:0]    req;
    logic [TRAPS-1:0]    tflag;
    logic [TRAPS-1:0]    tpend;
    logic                trap_busy;
    logic [2:0]          trap_lvl;
    logic                sw_pend;
    logic [7:0]          sw_num;
    logic [ER_CH-1:0]    er_prev;
    logic [ER_CH-1:0]    er_flag;
    logic [EXT_PINS-1:0] ext_prev;
    logic [7:0]          vec;
    logic [PRIO_W-1:0]   lvl;
    logic                is_trap;
    logic                hw_trap;
    logic [6:0]          node;
    logic [CH_IDX_W-1:0] ch;
    logic                mword;
  } ies_state_t;

  localparam ies_state_t IES_RST = '{st: ST_IDLE, default: '0};

endpackage

// file: interrupt_and_event_transfer_system_bench.sv
// Purpose: Self-checking bench for the interrupt and event transfer controller
// Assumes: Inputs change on the falling clock edge
// Notes:   Random stimulus from a fixed seed plus corner nodes
`timescale 1ns/1ps
`default_nettype none
module interrupt_and_event_transfer_system_bench;
  import ies_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i, jcache_i, svc_ack_i, mv_ack_i, ch_wr_i, trap_done_i, swtrap_i, slow;
  logic [DED_NODES-1:0] src_req_i;
  logic [SHR_SRCS-1:0] shr_src_i;
  logic [SHR_NODES*SHR_SEL_W-1:0] node_sel_i;
  logic [NODES-1:0] node_en_i, node_use_chan_i, sw_set_i, sw_clr_i, node_req_o;
  logic [NODES*PRIO_W-1:0] node_prio_i;
  logic [NODES*CH_IDX_W-1:0] node_chan_i;
  logic [PRIO_W-1:0] cpu_level_i, svc_lvl_o;
  logic [CHANNELS-1:0] ch_inc_src_i, ch_inc_dst_i, ch_word_i, ch_cont_i;
  logic [CH_IDX_W-1:0] ch_wr_sel_i;
  logic [CH_WORD_W-1:0] ch_wr_data_i;
  logic [ER_CH-1:0] er_in_i, er_flag_clr_i, er_flag_o;
  logic [2*ER_CH-1:0] er_edge_cfg_i, er_gmode_i;
  logic [ER_GATES*ER_CH-1:0] er_route_i, er_pat_i, er_pmask_i;
  logic [HW_TRAPS-1:0] hw_trap_i;
  logic [EXT_PINS-1:0] ext_trap_i, ext_en_i, ext_map_i;
  logic [TRAPS-1:0] trap_flag_clr_i, trap_flag_o;
  logic [7:0] swtrap_num_i, svc_vec_o;
  logic svc_req_o, svc_trap_o, mv_req_o, mv_word_o, ch_wr_ready_o, trap_busy_o;
  logic [PTR_W-1:0] mv_src_o, mv_dst_o;
  int errors = 0;
  int n_tests = 0;
  int i;

  always #4 clk_i = ~clk_i;

  ies_ctrl ies_ctrl_i (.*);
  ies_cpu_model ies_cpu_model_i (.clk_i(clk_i), .svc_req_i(svc_req_o), .mv_req_i(mv_req_o),
    .slow_i(slow), .svc_ack_o(svc_ack_i), .mv_ack_o(mv_ack_i));

  // Compare and count
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Expected gate decision for one event while all router flags are clear
  function automatic bit gate_pass(logic [1:0] md, logic [3:0] pat, logic [3:0] msk);
    return md == OGU_PASS || (md == OGU_MATCH && (pat & msk) == 4'h0)
        || (md == OGU_MISS && (pat & msk) != 4'h0);
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Count falling edges until a vector (mv=0) or move (mv=1) request shows
  task automatic wait_on(bit mv, output int n);
    n = 0;
    while ((mv ? mv_req_o : svc_req_o) !== 1'b1) begin
      @(negedge clk_i);
      n++;
      if (n > 40) begin
        errors++;
        results();
      end
    end
  endtask

  // Let the CPU answer: wait until neither a vector nor a move request shows, then one more clock
  task automatic settle();
    for (int k = 0; (svc_req_o | mv_req_o) !== 1'b0; k++) begin
      if (k == 20) begin
        errors++;
        results();
      end
      @(negedge clk_i);
    end
    @(negedge clk_i);
  endtask

  // One router input, one edge kind only, through one gate to its node
  task automatic t_router(int c, int j, bit fall);
    logic [1:0] md;
    logic [3:0] pat, msk;
    md = 2'($urandom);
    pat = 4'($urandom);
    msk = 4'($urandom);
    node_en_i = '0;
    {er_edge_cfg_i, er_route_i, er_gmode_i} = '0;
    er_edge_cfg_i[2*c+:2] = fall ? 2'b10 : 2'b01;
    er_route_i[4*j+c] = 1'b1;
    er_gmode_i[2*j+:2] = md;
    er_pat_i[4*j+:4] = pat;
    er_pmask_i[4*j+:4] = msk;
    for (int e = 0; e < 2; e++) begin
      er_in_i[c] = (e == 0);
      @(negedge clk_i);
      chk("edge flag", er_flag_o, (e == int'(fall)) ? 4'h1 << c : 4'h0);
      chk("gate", node_req_o[DED_NODES+SHR_NODES+j], (e == int'(fall)) && gate_pass(md, pat, msk));
      {er_flag_clr_i, sw_clr_i} = '1;
      @(negedge clk_i);
      {er_flag_clr_i, sw_clr_i} = '0;
    end
    chk("cleared", {er_flag_o, node_req_o[DED_NODES+SHR_NODES+j]}, 0);
    $display("router %0d gate %0d done", c, j);
  endtask

  // Software trap with a random vector number
  task automatic t_swtrap();
    int c;
    swtrap_num_i = 8'($urandom);
    swtrap_i = 1'b1;
    @(negedge clk_i);
    swtrap_i = 1'b0;
    wait_on(0, c);
    chk("sw latency", c, jcache_i ? RESP_JC_CYC : RESP_NJC_CYC);
    chk("sw trap", {svc_trap_o, svc_vec_o, svc_lvl_o}, {1'b1, swtrap_num_i, TRAP_LEVEL});
    settle();
    chk("sw busy", trap_busy_o, 0);
    $display("software trap %0h done", swtrap_num_i);
  endtask

  // Vectored service; low first holds the priority at the CPU level
  task automatic t_node(int n, bit low);
    int c;
    logic [3:0] p;
    p = 4'($urandom_range(15, 2));
    cpu_level_i = 4'($urandom_range(p - 1, 0));
    jcache_i = 1'($urandom);
    node_en_i = '0;
    node_en_i[n] = 1'b1;
    node_prio_i[4*n+:4] = p;
    if (n < DED_NODES) src_req_i[n] = 1'b1;
    else sw_set_i[n] = 1'b1;
    @(negedge clk_i);
    src_req_i = '0;
    sw_set_i = '0;
    if (low) begin
      cpu_level_i = p;
      repeat (15) @(negedge clk_i);
      chk("refused", {svc_req_o, node_req_o[n]}, 2'b01);
      cpu_level_i = p - 4'h1;
    end
    wait_on(0, c);
    if (!low) chk("latency", c, jcache_i ? RESP_JC_CYC : RESP_NJC_CYC);
    chk("vector", svc_vec_o, NODE_VEC_BASE + 8'(n));
    chk("level", svc_lvl_o, p);
    chk("flag", node_req_o[n], 0);
    settle();
    $display("node %0d done", n);
  endtask

  // Two channel moves, count runs out, then the node's vector; a continuous channel keeps its count and gives no vector
  task automatic t_chan(int n);
    int c;
    logic [2:0] h;
    logic [23:0] s, d, st;
    h = 3'($urandom);
    s = 24'($urandom);
    d = 24'($urandom);
    {ch_cont_i[h], ch_word_i[h], ch_inc_src_i[h], ch_inc_dst_i[h]} = 4'($urandom);
    st = ch_word_i[h] ? STEP_WORD : STEP_BYTE;
    {ch_wr_sel_i, ch_wr_data_i, ch_wr_i} = {h, s, d, 8'h02, 1'b1};
    @(negedge clk_i);
    ch_wr_i = 1'b0;
    node_en_i = '0;
    node_en_i[n] = 1'b1;
    node_prio_i[4*n+:4] = 4'h5;
    cpu_level_i = 4'h0;
    node_use_chan_i[n] = 1'b1;
    node_chan_i[3*n+:3] = h;
    for (int k = 0; k < 2; k++) begin
      sw_set_i[n] = 1'b1;
      @(negedge clk_i);
      sw_set_i = '0;
      wait_on(1, c);
      chk("move delay", c, 2);
      chk("move src", mv_src_o, ch_inc_src_i[h] ? 24'(s + 24'(k) * st) : s);
      chk("move dst", mv_dst_o, ch_inc_dst_i[h] ? 24'(d + 24'(k) * st) : d);
      chk("move size", mv_word_o, ch_word_i[h]);
      for (int j = 0; ch_wr_ready_o !== 1'b0; j++) begin
        if (j == 12) begin
          errors++;
          results();
        end
        @(negedge clk_i);
      end
      @(negedge clk_i);
      chk("write back", {mv_req_o, ch_wr_ready_o}, 2'b01);
      settle();
    end
    if (ch_cont_i[h]) begin
      repeat (15) @(negedge clk_i);
      chk("no end vector", svc_req_o, 0);
    end else begin
      wait_on(0, c);
      chk("end vector", {svc_trap_o, svc_vec_o}, {1'b0, NODE_VEC_BASE + 8'(n)});
      settle();
    end
    {node_use_chan_i[n], ch_cont_i[h]} = '0;
    $display("channel %0d done", h);
  endtask

  // Hardware trap, then a node held back until the trap returns
  task automatic t_trap(int t);
    int c;
    hw_trap_i[t] = 1'b1;
    @(negedge clk_i);
    hw_trap_i = '0;
    chk("trap flag", trap_flag_o, 8'h01 << t);
    wait_on(0, c);
    chk("trap vector", {svc_trap_o, svc_vec_o}, {1'b1, 8'(t)});
    settle();
    node_en_i = '0;
    node_en_i[3] = 1'b1;
    node_prio_i[12+:4] = 4'hf;
    cpu_level_i = 4'h0;
    sw_set_i[3] = 1'b1;
    @(negedge clk_i);
    sw_set_i = '0;
    repeat (15) @(negedge clk_i);
    chk("held", {trap_busy_o, svc_req_o, node_req_o[3]}, 3'b101);
    trap_done_i = 1'b1;
    trap_flag_clr_i = '1;
    @(negedge clk_i);
    {trap_done_i, trap_flag_clr_i} = '0;
    wait_on(0, c);
    chk("after trap", svc_vec_o, NODE_VEC_BASE + 8'h03);
    settle();
    $display("trap %0d done", t);
  endtask

  // Main sequence
  initial begin
    {nrst_i, jcache_i, ch_wr_i, trap_done_i, swtrap_i, slow, src_req_i, shr_src_i, node_sel_i,
     node_en_i, node_use_chan_i, sw_set_i, sw_clr_i, node_prio_i, node_chan_i, cpu_level_i,
     ch_inc_src_i, ch_inc_dst_i, ch_word_i, ch_cont_i, ch_wr_sel_i, ch_wr_data_i, er_in_i,
     er_flag_clr_i, er_edge_cfg_i, er_gmode_i, er_route_i, er_pat_i, er_pmask_i, hw_trap_i,
     ext_trap_i, ext_en_i, ext_map_i, trap_flag_clr_i, swtrap_num_i} = '0;
    void'($urandom(99742));
    repeat (20) @(negedge clk_i);
    nrst_i = 1'b1;
    chk("reset", {svc_req_o, mv_req_o, trap_flag_o, |node_req_o, ch_wr_ready_o}, 1);
    t_node(0, 0);
    t_node(95, 1);
    t_router(0, 0, 0);
    t_router(3, 3, 1);
    for (i = 0; i < 6; i++) begin
      slow = 1'($urandom);
      t_node($urandom_range(91, 1), i[0]);
      t_chan($urandom_range(83, 0));
      t_trap($urandom_range(5, 0));
      t_router($urandom_range(3, 0), $urandom_range(3, 0), i[1]);
      t_swtrap();
    end
    ext_en_i = '1;
    ext_map_i = 3'($urandom);
    i = $urandom_range(2, 0);
    ext_trap_i[i] = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("system request", trap_flag_o, 8'h01 << (ext_map_i[i] ? TRAP_SRB_BIT : TRAP_SRA_BIT));
    results();
  end
endmodule
`default_nettype wire
